/* rtl/gpio_port_pkg.sv */
// Constants shared by the three-pin port with serial channel multiplexing
package gpio_port_pkg;

	// Port geometry
	localparam int PORT_WIDTH = 3;
	localparam int REG_WIDTH = 8;
	localparam int SYNC_STAGES = 2;

	// Pin positions within the port
	localparam int TX_BIT = 0;
	localparam int RX_BIT = 1;
	localparam int SCK_BIT = 2;

	// Printed register offsets are indices; byte address is four times the index
	localparam logic [15:0] DIR_INDEX = 16'hFFB8;
	localparam logic [15:0] DATA_INDEX = 16'hFFBA;
	localparam logic [31:0] DIR_ADDR = {14'h0000, DIR_INDEX, 2'h0};
	localparam logic [31:0] DATA_ADDR = {14'h0000, DATA_INDEX, 2'h0};

	// Reset and read-back values
	localparam logic [7:0] DIR_RESET = 8'hF8;
	localparam logic [7:0] DATA_RESET = 8'hF8;
	localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
	localparam logic [4:0] RESERVED_ONES = 5'h1F;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Low byte lane strobe of the APB word
	localparam int LANE0 = 0;

endpackage

/* rtl/pin_ctrl_if.sv */
// Carrier between the port control logic and the pin cells
`timescale 1ns/1ps
interface pin_ctrl_if;
	import gpio_port_pkg::*;

	logic [PORT_WIDTH-1:0] drive_en;
	logic [PORT_WIDTH-1:0] drive_val;
	logic [PORT_WIDTH-1:0] level;

	modport ctrl (
		output drive_en,
		output drive_val,
		input level
	);

	modport pins (
		input drive_en,
		input drive_val,
		output level
	);

endinterface

/* rtl/pin_io_cell.sv */
// Pin cells: input synchronisers and output drivers for each port pin
`timescale 1ns/1ps
module pin_io_cell
	import gpio_port_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Control side
	pin_ctrl_if.pins bus,
	// Pad side
	input wire logic [PORT_WIDTH-1:0] i_pin_in,
	output logic [PORT_WIDTH-1:0] o_pin_out,
	output logic [PORT_WIDTH-1:0] o_pin_oe
);

	genvar g;
	generate
		for (g = 0; g < PORT_WIDTH; g++) begin : gen_pin
			logic meta;
			logic stable;

			// First stage feeds only the second; pads may change at any time
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta <= i_pin_in[g];
					stable <= meta;
				end
			end

			assign bus.level[g] = stable;
			assign o_pin_out[g] = bus.drive_val[g];
			assign o_pin_oe[g] = bus.drive_en[g];
		end
	endgenerate

endmodule // pin_io_cell

/* rtl/three_bit_port.sv */
// Three-pin general-purpose port shared with serial channel zero, APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module three_bit_port
	import gpio_port_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Chip standby states
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	// Serial channel zero mode and control bits
	input wire logic i_clock_enable_high,
	input wire logic i_clock_enable_low,
	input wire logic i_sync_mode,
	input wire logic i_receive_enable_bit,
	input wire logic i_transmit_enable_bit,
	// Serial channel zero data and clock
	input wire logic i_serial_tx_data,
	input wire logic i_serial_clock_out,
	output logic o_serial_rx_data,
	output logic o_serial_clock_in,
	// Port pins: serial_transmit_pin, serial_receive_pin, serial_clock_pin
	input wire logic [PORT_WIDTH-1:0] i_pin_in,
	output logic [PORT_WIDTH-1:0] o_pin_out,
	output logic [PORT_WIDTH-1:0] o_pin_oe
);

	pin_ctrl_if bus ();

	// Register state: only the implemented low bits are stored
	logic [PORT_WIDTH-1:0] pin_direction;
	logic [PORT_WIDTH-1:0] pin_data_latch;

	// Bus decode
	logic setup_phase;
	logic access_done;
	logic hit_dir;
	logic hit_data;
	logic lane0_write;
	logic err_pending;

	// Pin ownership
	logic serial_allowed;
	logic sck_is_input;
	logic sck_is_output;
	logic rx_is_input;
	logic tx_is_output;
	logic [PORT_WIDTH-1:0] owned;
	logic [PORT_WIDTH-1:0] read_bits;
	logic [31:0] next_prdata;

	assign setup_phase = i_psel && !i_penable;
	assign access_done = i_psel && i_penable;
	assign hit_dir = (i_paddr == DIR_ADDR);
	assign hit_data = (i_paddr == DATA_ADDR);
	assign lane0_write = i_pwrite && i_pstrb[LANE0];

	// Zero wait states; read data and error are captured in the setup cycle
	assign o_pready = access_done;
	assign o_pslverr = access_done && err_pending;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_pending <= 1'b0;
		end else if (setup_phase) begin
			err_pending <= !(hit_dir || hit_data);
		end
	end

	// Direction register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_direction <= DIR_RESET[PORT_WIDTH-1:0];
		end else if (i_hw_standby) begin
			pin_direction <= DIR_RESET[PORT_WIDTH-1:0];
		end else if (access_done && hit_dir && lane0_write) begin
			// Software standby does not block or clear this path
			pin_direction <= i_pwdata[PORT_WIDTH-1:0];
		end
	end

	// Data latch; upper bits are not stored so writes to them vanish
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_data_latch <= DATA_RESET[PORT_WIDTH-1:0];
		end else if (i_hw_standby) begin
			pin_data_latch <= DATA_RESET[PORT_WIDTH-1:0];
		end else if (access_done && hit_data && lane0_write) begin
			pin_data_latch <= i_pwdata[PORT_WIDTH-1:0];
		end
	end

	// Ownership: both standby states return every pin to the port
	assign serial_allowed = !i_sw_standby && !i_hw_standby;
	assign sck_is_input = serial_allowed && i_clock_enable_high;
	assign sck_is_output = serial_allowed && !i_clock_enable_high
		&& (i_sync_mode || i_clock_enable_low);
	assign rx_is_input = serial_allowed && i_receive_enable_bit;
	assign tx_is_output = serial_allowed && i_transmit_enable_bit;

	always_comb begin
		owned = '0;
		owned[SCK_BIT] = sck_is_input || sck_is_output;
		owned[RX_BIT] = rx_is_input;
		owned[TX_BIT] = tx_is_output;
	end

	// Pin drive; hardware standby floats every pin
	always_comb begin
		bus.drive_en = '0;
		bus.drive_val = pin_data_latch;
		if (!i_hw_standby) begin
			bus.drive_en = pin_direction & ~owned;
			if (sck_is_output) begin
				bus.drive_en[SCK_BIT] = 1'b1;
				bus.drive_val[SCK_BIT] = i_serial_clock_out;
			end
			if (tx_is_output) begin
				bus.drive_en[TX_BIT] = 1'b1;
				bus.drive_val[TX_BIT] = i_serial_tx_data;
			end
		end
	end

	// Channel sees the synchronised pin level whatever the port owns
	assign o_serial_rx_data = bus.level[RX_BIT];
	assign o_serial_clock_in = bus.level[SCK_BIT];

	// Read mux: latch for outputs, pin level otherwise, even under the channel
	assign read_bits = (pin_direction & pin_data_latch)
		| (~pin_direction & bus.level);

	always_comb begin
		next_prdata = UNMAPPED_READ;
		if (hit_dir) begin
			next_prdata[REG_WIDTH-1:0] = DIR_READ_VALUE;
		end else if (hit_data) begin
			next_prdata[REG_WIDTH-1:0] = {RESERVED_ONES, read_bits};
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= UNMAPPED_READ;
		end else if (setup_phase) begin
			o_prdata <= next_prdata;
		end
	end

	pin_io_cell u_pins (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.bus(bus.pins),
		.i_pin_in(i_pin_in),
		.o_pin_out(o_pin_out),
		.o_pin_oe(o_pin_oe)
	);

	// Transmit pin ownership
	tx_owned_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_transmit_enable_bit && !i_sw_standby && !i_hw_standby)
		|-> (o_pin_oe[TX_BIT] && o_pin_out[TX_BIT] == i_serial_tx_data)
	) else $error("transmit pin not driven by serial data");

	// Receive pin is a pure input while the channel owns it
	rx_owned_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_receive_enable_bit && !i_sw_standby && !i_hw_standby)
		|-> !o_pin_oe[RX_BIT]
	) else $error("receive pin driven while receiving");

	// Clock pin as serial clock input
	sck_input_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_clock_enable_high && !i_sw_standby && !i_hw_standby)
		|-> !o_pin_oe[SCK_BIT]
	) else $error("clock pin driven in external clock mode");

	// Clock pin as serial clock output
	sck_output_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(!i_clock_enable_high && (i_sync_mode || i_clock_enable_low)
			&& !i_sw_standby && !i_hw_standby)
		|-> (o_pin_oe[SCK_BIT] && o_pin_out[SCK_BIT] == i_serial_clock_out)
	) else $error("clock pin not driving serial clock");

	// Pins under port control follow direction and latch
	gp_control_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_sw_standby && !i_hw_standby)
		|-> (o_pin_oe == pin_direction
			&& (o_pin_out & pin_direction) == (pin_data_latch & pin_direction))
	) else $error("pin drive does not follow port registers");

	// Software standby releases every channel-owned pin
	sw_release_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		i_sw_standby |-> (owned == '0)
	) else $error("channel still owns a pin in software standby");

	// Direction reads always return all ones
	dir_read_ones_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && !i_pwrite && hit_dir)
		|-> (o_prdata[REG_WIDTH-1:0] == DIR_READ_VALUE && !o_pslverr)
	) else $error("direction read did not return all ones");

	// Reserved data bits read as ones
	reserved_ones_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && !i_pwrite && hit_data)
		|-> (o_prdata[REG_WIDTH-1:PORT_WIDTH] == RESERVED_ONES)
	) else $error("reserved data bits not read as one");

	// Read value captured from latch or pin level by direction
	read_level_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(setup_phase && hit_data && !i_hw_standby)
		|=> (o_prdata[PORT_WIDTH-1:0] == (($past(pin_direction) & $past(pin_data_latch))
			| (~$past(pin_direction) & $past(bus.level))))
	) else $error("port read value wrong");

	// Hardware standby reinitialises both registers
	hw_standby_init_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		i_hw_standby |=> (pin_direction == DIR_RESET[PORT_WIDTH-1:0]
			&& pin_data_latch == DATA_RESET[PORT_WIDTH-1:0]
			&& (!i_hw_standby || o_pin_oe == '0))
	) else $error("hardware standby did not reinitialise port");

	// Software standby keeps both registers when nothing is written
	sw_standby_keep_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_sw_standby && !i_hw_standby && !(access_done && i_pwrite))
		|=> ($stable(pin_direction) && $stable(pin_data_latch))
	) else $error("software standby lost register contents");

	// A completed direction write reaches the direction register on the next cycle
	write_effect_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && hit_dir && lane0_write && !i_hw_standby)
		|=> (pin_direction == $past(i_pwdata[PORT_WIDTH-1:0]))
	) else $error("direction write did not take effect");

	// Unmapped addresses answer with an error
	unmapped_err_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && !hit_dir && !hit_data) |-> o_pslverr
	) else $error("unmapped access without error");

	// Reset holds both registers at their initial value
	reset_init_a: assert property (
		@(posedge i_clock)
		($past(!i_rst_n) && !i_rst_n) |-> (pin_direction == DIR_RESET[PORT_WIDTH-1:0]
			&& pin_data_latch == DATA_RESET[PORT_WIDTH-1:0])
	) else $error("reset did not initialise port registers");

	// Hardware standby floats every pin at once
	hw_float_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		i_hw_standby |-> (o_pin_oe == '0)
	) else $error("pin driven in hardware standby");

	// Transmit pin under port control follows direction and latch
	tx_port_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		((!i_transmit_enable_bit || i_sw_standby) && !i_hw_standby)
		|-> (o_pin_oe[TX_BIT] == pin_direction[TX_BIT]
			&& (!pin_direction[TX_BIT] || o_pin_out[TX_BIT] == pin_data_latch[TX_BIT]))
	) else $error("transmit pin not under port control");

	// Receive pin under port control follows direction
	rx_port_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		((!i_receive_enable_bit || i_sw_standby) && !i_hw_standby)
		|-> (o_pin_oe[RX_BIT] == pin_direction[RX_BIT])
	) else $error("receive pin not under port control");

	// Clock pin under port control follows direction
	sck_port_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(((!i_clock_enable_high && !i_sync_mode && !i_clock_enable_low) || i_sw_standby)
			&& !i_hw_standby)
		|-> (o_pin_oe[SCK_BIT] == pin_direction[SCK_BIT])
	) else $error("clock pin not under port control");

	// Channel receive data is the pad level two edges late
	rx_sync_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		($past(i_rst_n) && $past(i_rst_n, SYNC_STAGES))
		|-> (o_serial_rx_data == $past(i_pin_in[RX_BIT], SYNC_STAGES))
	) else $error("receive data is not the synchronised pad level");

	// Channel clock input is the pad level two edges late
	sck_sync_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		($past(i_rst_n) && $past(i_rst_n, SYNC_STAGES))
		|-> (o_serial_clock_in == $past(i_pin_in[SCK_BIT], SYNC_STAGES))
	) else $error("clock input is not the synchronised pad level");

	// A completed data write reaches the latch on the next cycle
	data_write_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && hit_data && lane0_write && !i_hw_standby)
		|=> (pin_data_latch == $past(i_pwdata[PORT_WIDTH-1:0]))
	) else $error("data write did not take effect");

	// Writes without the low byte lane leave both registers alone
	masked_write_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && i_pwrite && !i_pstrb[LANE0] && !i_hw_standby)
		|=> ($stable(pin_direction) && $stable(pin_data_latch))
	) else $error("masked write changed a register");

	// Unmapped accesses leave both registers alone
	unmapped_keep_a: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(access_done && !hit_dir && !hit_data && !i_hw_standby)
		|=> ($stable(pin_direction) && $stable(pin_data_latch))
	) else $error("unmapped access changed a register");

endmodule // three_bit_port

/* bench/board_model.sv */
// Board model: pads follow the port where it drives, else the board level
`timescale 1ns/1ps
module board_model
	import gpio_port_pkg::*;
(
	// Port side
	input wire logic [PORT_WIDTH-1:0] i_pin_out,
	input wire logic [PORT_WIDTH-1:0] i_pin_oe,
	// Board side
	input wire logic [PORT_WIDTH-1:0] i_ext,
	output logic [PORT_WIDTH-1:0] o_pin_in
);
	assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule // board_model

/* bench/testbench.sv */
// Self-checking bench for the three-pin port
`timescale 1ns/1ps
module testbench;
	import gpio_port_pkg::*;
	logic i_clock, i_rst_n, psel, pen, pwr, hw, sw, ckh, ckl, sy, rxe, txe, txd, cko;
	logic o_pready, o_pslverr, err, rxd_in, sck_in;
	logic [31:0] paddr, pwdata, o_prdata, rd, wd;
	logic [3:0] pstrb;
	logic [2:0] pin_in, pin_out, pin_oe, ext, dir_m, lat_m, lvl;
	logic [5:0] e;
	int n_mismatch, n_compared;

	three_bit_port DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_hw_standby(hw), .i_sw_standby(sw),
		.i_clock_enable_high(ckh), .i_clock_enable_low(ckl), .i_sync_mode(sy),
		.i_receive_enable_bit(rxe), .i_transmit_enable_bit(txe),
		.i_serial_tx_data(txd), .i_serial_clock_out(cko), .o_serial_rx_data(rxd_in),
		.o_serial_clock_in(sck_in), .i_pin_in(pin_in), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe));
	board_model partner (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext(ext),
		.o_pin_in(pin_in));

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			n_mismatch++;
		end
	endtask

	task automatic print_verdict();
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		@(posedge i_clock);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge i_clock);
		pen <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge i_clock);
			if (o_pready === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			print_verdict();
		end
		rd = o_prdata;
		err = o_pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// Expected {oe, driven value} from registers and channel controls
	function automatic logic [5:0] exp_pins();
		logic [2:0] oe;
		logic [2:0] out;
		oe = dir_m;
		out = lat_m;
		if (txe && !sw) begin
			oe[TX_BIT] = 1'b1;
			out[TX_BIT] = txd;
		end
		if (rxe && !sw) oe[RX_BIT] = 1'b0;
		if (ckh && !sw) begin
			oe[SCK_BIT] = 1'b0;
		end else if ((sy || ckl) && !sw) begin
			oe[SCK_BIT] = 1'b1;
			out[SCK_BIT] = cko;
		end
		if (hw) oe = 3'h0;
		return {oe, out & oe};
	endfunction

	// Three edges let the two-stage synchroniser settle
	task automatic check_pins();
		repeat (3) @(posedge i_clock);
		e = exp_pins();
		check({26'h0, pin_oe, pin_out & pin_oe}, {26'h0, e});
		lvl = (e[5:3] & e[2:0]) | (~e[5:3] & ext);
		check({30'h0, sck_in, rxd_in}, {30'h0, lvl[2:1]});
		apb(1'b0, DATA_ADDR, 32'h0, 4'h0);
		check(rd, {24'h0, RESERVED_ONES, (dir_m & lat_m) | (~dir_m & lvl)});
	endtask

	initial begin
		{i_rst_n, psel, pen, pwr, hw, sw, ckh, ckl, sy, rxe, txe, txd, cko} = 13'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		ext = 3'h5;
		dir_m = 3'h0;
		lat_m = 3'h0;
		n_mismatch = 0;
		n_compared = 0;
		void'($urandom(32'h40b9a3b0));
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		check_pins();
		apb(1'b0, DIR_ADDR, 32'h0, 4'h0);
		check(rd, 32'h0000_00FF);
		$display("Test reset done");
		// Every channel control combination, random registers and pads
		for (int i = 0; i < 64; i++) begin
			wd = $urandom();
			dir_m = wd[2:0];
			apb(1'b1, DIR_ADDR, wd, 4'hF);
			wd = $urandom();
			lat_m = wd[2:0];
			apb(1'b1, DATA_ADDR, wd, 4'h1);
			@(posedge i_clock);
			{sw, ckh, ckl, sy, rxe, txe} <= i[5:0];
			{txd, cko, ext} <= 5'($urandom());
			check_pins();
			apb(1'b0, DIR_ADDR, 32'h0, 4'h0);
			check(rd, 32'h0000_00FF);
		end
		$display("Test modes done");
		// Masked lane and unmapped words change nothing
		apb(1'b1, DATA_ADDR, ~{29'h0, lat_m}, 4'hE);
		apb(1'b0, DATA_ADDR + 32'h4, 32'h0, 4'h0);
		check({31'h0, err}, 32'h1);
		check(rd, UNMAPPED_READ);
		apb(1'b1, DIR_ADDR - 32'h4, 32'h7, 4'hF);
		check_pins();
		$display("Test refusals done");
		// Hardware standby while all pins drive
		{sw, ckh, ckl, sy, rxe, txe} <= 6'h0;
		apb(1'b1, DIR_ADDR, 32'h7, 4'h1);
		apb(1'b1, DATA_ADDR, 32'h5, 4'h1);
		dir_m = 3'h7;
		lat_m = 3'h5;
		check_pins();
		hw <= 1'b1;
		dir_m = 3'h0;
		lat_m = 3'h0;
		apb(1'b1, DIR_ADDR, 32'h7, 4'h1);
		check_pins();
		hw <= 1'b0;
		check_pins();
		$display("Test standby done");
		print_verdict();
	end
endmodule // testbench
